//--- verilog/selector_pkg.sv
/*
  selector_pkg: register word indexes, field codes, reset values,
  frequency constants and carriers of the setpoint source selector.
  assumes a word-addressed Avalon-MM slave with 32-bit data and
  frequencies in 0.01 Hz steps.
*/
package selector_pkg;
  localparam int unsigned FREQ_W = 16;
  localparam int unsigned OFS_W = FREQ_W + 2;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = DATA_W / 8;
  localparam int unsigned SRC_W = 4;
  localparam int unsigned BIND_W = 12;
  localparam int unsigned CH_W = 2;

  // word index; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_STOP_MEM = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_MOTOR_SET = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_RAMP_REF = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_CORR_BASE = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_BINDING = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_PROTOCOL = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_PRESET = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_MAX_FREQ = 4'h7;
  localparam logic [ADDR_W-1:0] IDX_MAIN_SRC = 4'h8;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 4'h9;
  localparam logic [ADDR_W-1:0] IDX_SETPOINT = 4'hA;
  localparam logic [ADDR_W-1:0] IDX_TARGET = 4'hB;

  // field codes
  localparam logic STOP_NO_MEM = 1'b0;
  localparam logic STOP_MEM = 1'b1;
  localparam logic MOTOR_ONE = 1'b0;
  localparam logic MOTOR_TWO = 1'b1;
  localparam logic [1:0] RAMP_MAX = 2'h0;
  localparam logic [1:0] RAMP_SET = 2'h1;
  localparam logic [1:0] RAMP_100HZ = 2'h2;
  localparam logic CORR_OPER = 1'b0;
  localparam logic CORR_SET = 1'b1;
  localparam logic PROTO_MODBUS = 1'b0;
  localparam logic PROTO_FIELDBUS = 1'b1;

  // frequency source codes, one decimal digit each
  localparam logic [SRC_W-1:0] SRC_UNBOUND = 4'h0;
  localparam logic [SRC_W-1:0] SRC_DIGITAL = 4'h1;
  localparam logic [SRC_W-1:0] SRC_LAST = 4'h9;

  // command channels and their digit position in the binding word
  localparam logic [CH_W-1:0] CH_KEYPAD = 2'h0;
  localparam logic [CH_W-1:0] CH_TERMINAL = 2'h1;
  localparam logic [CH_W-1:0] CH_COMM = 2'h2;
  localparam int unsigned BIND_KEY_LSB = 0;
  localparam int unsigned BIND_TERM_LSB = 4;
  localparam int unsigned BIND_COMM_LSB = 8;

  // status word layout
  localparam int unsigned STAT_MOTOR_BIT = 0;
  localparam int unsigned STAT_BOUND_BIT = 1;
  localparam int unsigned STAT_RUN_BIT = 2;
  localparam int unsigned STAT_SRC_LSB = 4;

  // reset values and fixed frequencies, 0.01 Hz units
  localparam logic [FREQ_W-1:0] PRESET_RST = 16'h1388;
  localparam logic [FREQ_W-1:0] MAX_FREQ_RST = 16'h1388;
  localparam logic [FREQ_W-1:0] FREQ_100HZ = 16'h2710;

  typedef struct packed {
    logic up;
    logic down;
  } updown_t;

  typedef struct packed {
    logic motor_set;
    logic bound;
    logic [SRC_W-1:0] source;
  } drive_sel_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;
endpackage : selector_pkg

//--- verilog/pin_sync.sv
/*
  pin_sync: three-stage synchroniser for slow pins; the filtered
  level follows only when the second and third stages agree.
  assumes pins are asynchronous to core_clk.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // pins and filtered level
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] nxt_level;

  always_comb begin
    nxt_level = (~(s2_ff ^ s3_ff) & s2_ff) | ((s2_ff ^ s3_ff) & level_ff);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      level_ff <= '0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level = level_ff;
endmodule : pin_sync

//--- verilog/freq_clamp.sv
/*
  freq_clamp: limits a signed frequency sum to zero .. limit.
  assumes limit is an unsigned frequency of the package width.
*/
`timescale 1ns/1ns
module freq_clamp (
  // signed sum and ceiling
  input wire logic signed [selector_pkg::OFS_W-1:0] value,
  input wire logic [selector_pkg::FREQ_W-1:0] limit,
  // limited frequency
  output logic [selector_pkg::FREQ_W-1:0] result
);
  import selector_pkg::*;

  logic signed [OFS_W-1:0] lim_s;

  always_comb begin
    lim_s = $signed(OFS_W'(limit));
    if (value < $signed(OFS_W'(0))) begin
      result = '0;
    end else if (value > lim_s) begin
      result = limit;
    end else begin
      result = value[FREQ_W-1:0];
    end
  end
endmodule : freq_clamp

//--- verilog/setpoint_source_selector.sv
/*
  setpoint_source_selector: register file, frequency source choice,
  digital setpoint with up/down correction and stop memory, motor set
  choice, ramp reference and serial protocol selection.
  assumes run_active, cmd_channel, operating_freq, source_freq and
  keypad_updown come from logic on core_clk; terminal pins are async.
  // Contract
  // - no stop memory: reload preset setpoint, clear correction at each stop
  // - stop memory: keep setpoint and correction as they stood
  // - stop memory acts only while digital setting is the source
  // - motor set selector 0 picks set one, 1 picks set two
  // - terminal motor-set choice overrides the stored selector
  // - ramp reference: 0 maximum, 1 set frequency, 2 fixed 100Hz
  // - set-frequency reference follows every setpoint change
  // - up/down base: 0 operating frequency, 1 set frequency, digital only
  // - binding word: one digit per channel, keypad, terminal, comm
  // - bound source overrides the main frequency source
  // - several channels may bind the same source
  // - protocol selector 0 Modbus, 1 fieldbus adapter
  // - stop memory selector 0 discard, 1 retain, reset to 1
*/
`timescale 1ns/1ns
module setpoint_source_selector #(
  parameter logic [selector_pkg::FREQ_W-1:0] UPDOWN_STEP = 16'h0001
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [selector_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [selector_pkg::BE_W-1:0] avs_byteenable,
  input wire logic [selector_pkg::DATA_W-1:0] avs_writedata,
  output logic [selector_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // drive state
  input wire logic run_active,
  input wire logic [selector_pkg::CH_W-1:0] cmd_channel,
  input wire logic [selector_pkg::FREQ_W-1:0] operating_freq,
  input wire logic [selector_pkg::FREQ_W-1:0] source_freq,
  // keypad and input terminals
  input wire selector_pkg::updown_t keypad_updown,
  input wire selector_pkg::updown_t terminal_updown_pin,
  input wire logic motor_set_terminal_pin,
  input wire logic motor_terminal_assigned,
  // towards ramp and motor control
  output selector_pkg::drive_sel_t drive_sel,
  output logic [selector_pkg::FREQ_W-1:0] target_freq,
  output logic [selector_pkg::FREQ_W-1:0] ramp_ref_freq,
  output logic serial_protocol
);
  import selector_pkg::*;

  // binding digit of one command channel; codes above nine unbound
  function automatic logic [SRC_W-1:0] bind_digit(
    input logic [BIND_W-1:0] word,
    input logic [CH_W-1:0] ch
  );
    logic [SRC_W-1:0] d;
    d = SRC_UNBOUND;
    case (ch)
      CH_KEYPAD: d = word[BIND_KEY_LSB +: SRC_W];
      CH_TERMINAL: d = word[BIND_TERM_LSB +: SRC_W];
      CH_COMM: d = word[BIND_COMM_LSB +: SRC_W];
      default: d = SRC_UNBOUND;
    endcase
    bind_digit = (d > SRC_LAST) ? SRC_UNBOUND : d;
  endfunction : bind_digit

  // byte-lane merge of a 16-bit register
  function automatic logic [FREQ_W-1:0] merge16(
    input logic [FREQ_W-1:0] old,
    input logic [DATA_W-1:0] wd,
    input logic [BE_W-1:0] be
  );
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic signed [OFS_W-1:0] to_s(
    input logic [FREQ_W-1:0] f
  );
    to_s = $signed(OFS_W'(f));
  endfunction : to_s

  // terminal pins
  logic [2:0] term_level;
  logic term_up_lvl;
  logic term_dn_lvl;
  logic motor_term_lvl;

  pin_sync #(
    .WIDTH(3)
  ) u_term_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin({motor_set_terminal_pin, terminal_updown_pin.up, terminal_updown_pin.down}),
    .level(term_level)
  );

  assign motor_term_lvl = term_level[2];
  assign term_up_lvl = term_level[1];
  assign term_dn_lvl = term_level[0];

  // configuration registers and bus
  bus_state_t bus_state_ff, nxt_bus_state;
  logic wait_ff, nxt_wait;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [DATA_W-1:0] rd_mux;
  logic stop_mem_ff, nxt_stop_mem;
  logic motor_sel_ff, nxt_motor_sel;
  logic [1:0] ramp_sel_ff, nxt_ramp_sel;
  logic corr_base_ff, nxt_corr_base;
  logic [BIND_W-1:0] binding_ff, nxt_binding;
  logic proto_ff, nxt_proto;
  logic [FREQ_W-1:0] preset_ff, nxt_preset;
  logic [FREQ_W-1:0] max_ff, nxt_max;
  logic [SRC_W-1:0] main_src_ff, nxt_main_src;

  // setpoint state
  logic [FREQ_W-1:0] dig_set_ff, nxt_dig_set;
  logic signed [OFS_W-1:0] offset_ff, nxt_offset;
  logic run_prev_ff;
  logic [1:0] term_prev_ff;

  // output state
  drive_sel_t sel_ff, nxt_sel;
  logic [FREQ_W-1:0] target_ff, nxt_target;
  logic [FREQ_W-1:0] ramp_ref_ff, nxt_ramp_ref;
  logic proto_out_ff;

  // source choice and correction path
  logic [SRC_W-1:0] bound_src;
  logic [SRC_W-1:0] eff_src;
  logic digital;
  logic stop_evt;
  logic ud_up;
  logic ud_dn;
  logic signed [OFS_W-1:0] corr_sum;
  logic signed [OFS_W-1:0] target_sum;
  logic [FREQ_W-1:0] corr_new;
  logic [FREQ_W-1:0] target_new;

  always_comb begin
    bound_src = bind_digit(binding_ff, cmd_channel);
    eff_src = (bound_src != SRC_UNBOUND) ? bound_src : main_src_ff;
    digital = (eff_src == SRC_DIGITAL);
    stop_evt = run_prev_ff & ~run_active;
    ud_up = keypad_updown.up | (term_up_lvl & ~term_prev_ff[1]);
    ud_dn = keypad_updown.down | (term_dn_lvl & ~term_prev_ff[0]);
  end

  // correction base: operating or set frequency
  always_comb begin
    corr_sum = (corr_base_ff == CORR_OPER) ? to_s(operating_freq) : to_s(target_ff);
    if (ud_up) begin
      corr_sum = corr_sum + to_s(UPDOWN_STEP);
    end else begin
      corr_sum = corr_sum - to_s(UPDOWN_STEP);
    end
    target_sum = digital ? (to_s(dig_set_ff) + offset_ff) : to_s(source_freq);
  end

  freq_clamp u_corr_clamp (
    .value(corr_sum),
    .limit(max_ff),
    .result(corr_new)
  );

  freq_clamp u_target_clamp (
    .value(target_sum),
    .limit(max_ff),
    .result(target_new)
  );

  // read mux
  always_comb begin
    rd_mux = '0;
    case (avs_address)
      IDX_STOP_MEM: rd_mux = DATA_W'(stop_mem_ff);
      IDX_MOTOR_SET: rd_mux = DATA_W'(motor_sel_ff);
      IDX_RAMP_REF: rd_mux = DATA_W'(ramp_sel_ff);
      IDX_CORR_BASE: rd_mux = DATA_W'(corr_base_ff);
      IDX_BINDING: rd_mux = DATA_W'(binding_ff);
      IDX_PROTOCOL: rd_mux = DATA_W'(proto_ff);
      IDX_PRESET: rd_mux = DATA_W'(preset_ff);
      IDX_MAX_FREQ: rd_mux = DATA_W'(max_ff);
      IDX_MAIN_SRC: rd_mux = DATA_W'(main_src_ff);
      IDX_STATUS: begin
        rd_mux[STAT_MOTOR_BIT] = sel_ff.motor_set;
        rd_mux[STAT_BOUND_BIT] = sel_ff.bound;
        rd_mux[STAT_RUN_BIT] = run_prev_ff;
        rd_mux[STAT_SRC_LSB +: SRC_W] = sel_ff.source;
      end
      IDX_SETPOINT: rd_mux = DATA_W'(dig_set_ff);
      IDX_TARGET: rd_mux = DATA_W'(target_ff);
      default: rd_mux = '0;
    endcase
  end

  // bus handshake and register writes
  always_comb begin
    logic [FREQ_W-1:0] wv;
    wv = merge16(rd_mux[FREQ_W-1:0], avs_writedata, avs_byteenable);
    nxt_bus_state = bus_state_ff;
    nxt_wait = wait_ff;
    nxt_rdata = rdata_ff;
    nxt_stop_mem = stop_mem_ff;
    nxt_motor_sel = motor_sel_ff;
    nxt_ramp_sel = ramp_sel_ff;
    nxt_corr_base = corr_base_ff;
    nxt_binding = binding_ff;
    nxt_proto = proto_ff;
    nxt_preset = preset_ff;
    nxt_max = max_ff;
    nxt_main_src = main_src_ff;
    case (bus_state_ff)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_bus_state = BUS_ACK;
          nxt_wait = 1'b0;
          nxt_rdata = avs_read ? rd_mux : '0;
        end
      end
      BUS_ACK: begin
        nxt_bus_state = BUS_IDLE;
        nxt_wait = 1'b1;
        if (avs_write) begin
          case (avs_address)
            IDX_STOP_MEM: nxt_stop_mem = wv[0];
            IDX_MOTOR_SET: nxt_motor_sel = wv[0];
            IDX_RAMP_REF: nxt_ramp_sel = wv[1:0];
            IDX_CORR_BASE: nxt_corr_base = wv[0];
            IDX_BINDING: nxt_binding = wv[BIND_W-1:0];
            IDX_PROTOCOL: nxt_proto = wv[0];
            IDX_PRESET: nxt_preset = wv;
            IDX_MAX_FREQ: nxt_max = wv;
            IDX_MAIN_SRC: nxt_main_src = wv[SRC_W-1:0];
            default: nxt_main_src = main_src_ff;
          endcase
        end
      end
      default: begin
        nxt_bus_state = BUS_IDLE;
        nxt_wait = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bus_state_ff <= BUS_IDLE;
      wait_ff <= 1'b1;
      rdata_ff <= '0;
      stop_mem_ff <= STOP_MEM;
      motor_sel_ff <= MOTOR_ONE;
      ramp_sel_ff <= RAMP_MAX;
      corr_base_ff <= CORR_OPER;
      binding_ff <= '0;
      proto_ff <= PROTO_MODBUS;
      preset_ff <= PRESET_RST;
      max_ff <= MAX_FREQ_RST;
      main_src_ff <= SRC_DIGITAL;
    end else begin
      bus_state_ff <= nxt_bus_state;
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      stop_mem_ff <= nxt_stop_mem;
      motor_sel_ff <= nxt_motor_sel;
      ramp_sel_ff <= nxt_ramp_sel;
      corr_base_ff <= nxt_corr_base;
      binding_ff <= nxt_binding;
      proto_ff <= nxt_proto;
      preset_ff <= nxt_preset;
      max_ff <= nxt_max;
      main_src_ff <= nxt_main_src;
    end
  end

  // digital setpoint, stop memory and up/down correction
  always_comb begin
    nxt_dig_set = dig_set_ff;
    nxt_offset = offset_ff;
    if (stop_evt && digital && (stop_mem_ff == STOP_NO_MEM)) begin
      nxt_dig_set = preset_ff;
      nxt_offset = '0;
    end else if (digital && (ud_up ^ ud_dn)) begin
      nxt_offset = to_s(corr_new) - to_s(dig_set_ff);
    end
    // with memory on, a stop leaves both untouched
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dig_set_ff <= PRESET_RST;
      offset_ff <= '0;
      run_prev_ff <= 1'b0;
      term_prev_ff <= '0;
    end else begin
      dig_set_ff <= nxt_dig_set;
      offset_ff <= nxt_offset;
      run_prev_ff <= run_active;
      term_prev_ff <= {term_up_lvl, term_dn_lvl};
    end
  end

  // selections towards ramp and motor control
  always_comb begin
    nxt_sel.source = eff_src;
    nxt_sel.bound = (bound_src != SRC_UNBOUND);
    nxt_sel.motor_set = motor_terminal_assigned ? motor_term_lvl : motor_sel_ff;
    nxt_target = target_new;
    case (ramp_sel_ff)
      RAMP_MAX: nxt_ramp_ref = max_ff;
      RAMP_SET: nxt_ramp_ref = target_new;
      RAMP_100HZ: nxt_ramp_ref = FREQ_100HZ;
      default: nxt_ramp_ref = max_ff;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sel_ff <= '0;
      target_ff <= '0;
      ramp_ref_ff <= MAX_FREQ_RST;
      proto_out_ff <= PROTO_MODBUS;
    end else begin
      sel_ff <= nxt_sel;
      target_ff <= nxt_target;
      ramp_ref_ff <= nxt_ramp_ref;
      proto_out_ff <= proto_ff;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign drive_sel = sel_ff;
  assign target_freq = target_ff;
  assign ramp_ref_freq = ramp_ref_ff;
  assign serial_protocol = proto_out_ff;

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence digital_stop_s;
    stop_evt && digital;
  endsequence

  sequence bus_req_s;
    (avs_read || avs_write) && (bus_state_ff == BUS_IDLE);
  endsequence

  stop_reload_a: assert property (
    digital_stop_s ##0 (stop_mem_ff == STOP_NO_MEM) |=>
      (dig_set_ff == $past(preset_ff)) && (offset_ff == '0))
    else $error("setpoint not reloaded at stop");

  stop_keep_a: assert property (
    digital_stop_s ##0 (stop_mem_ff == STOP_MEM) ##0 !(ud_up ^ ud_dn) |=>
      $stable(dig_set_ff) && $stable(offset_ff))
    else $error("setpoint lost at stop with memory");

  other_source_a: assert property (
    !digital |=> $stable(dig_set_ff) && $stable(offset_ff))
    else $error("setpoint moved under other source");

  motor_reg_a: assert property (
    !motor_terminal_assigned |=> drive_sel.motor_set == $past(motor_sel_ff))
    else $error("motor set does not follow selector");

  motor_term_a: assert property (
    motor_terminal_assigned |=> drive_sel.motor_set == $past(motor_term_lvl))
    else $error("terminal motor set not preferred");

  ramp_fixed_a: assert property (
    (ramp_sel_ff == RAMP_100HZ) [*2] |-> ramp_ref_freq == FREQ_100HZ)
    else $error("fixed ramp reference wrong");

  ramp_follow_a: assert property (
    (ramp_sel_ff == RAMP_SET) |=> ramp_ref_freq == target_freq)
    else $error("ramp reference not following setpoint");

  corr_oper_a: assert property (
    digital && ud_up && !ud_dn && !stop_evt && (corr_base_ff == CORR_OPER) &&
      (to_s(operating_freq) + to_s(UPDOWN_STEP) <= to_s(max_ff)) |=>
      to_s(dig_set_ff) + offset_ff ==
        to_s($past(operating_freq)) + to_s(UPDOWN_STEP))
    else $error("correction not based on operating frequency");

  bound_src_a: assert property (
    (bound_src != SRC_UNBOUND) |=> drive_sel.bound && (drive_sel.source == $past(bound_src)))
    else $error("bound source not used");

  proto_sel_a: assert property (
    $stable(proto_ff) |=> serial_protocol == $past(proto_ff))
    else $error("protocol select not forwarded");

  target_limit_a: assert property (
    target_freq <= $past(max_ff))
    else $error("target above maximum frequency");

  bus_answer_a: assert property (
    bus_req_s |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
endmodule : setpoint_source_selector

//--- sim/drive_partner.sv
/*
  drive_partner: keypad, input terminals and drive state as seen by the selector.
  assumes the bench calls its tasks; all changes land just after core_clk rises.
*/
`timescale 1ns/1ns
module drive_partner (
  // clock
  input wire logic core_clk,
  // drive state and operator inputs
  output logic run_active,
  output logic [1:0] cmd_channel,
  output logic [15:0] operating_freq,
  output logic [15:0] source_freq,
  output logic [1:0] keypad_updown,
  output logic [1:0] terminal_updown_pin,
  output logic motor_set_terminal_pin,
  output logic motor_terminal_assigned
);
  initial begin
    run_active = 1'b0;
    cmd_channel = 2'h3;
    operating_freq = 16'h0000;
    source_freq = 16'h0000;
    keypad_updown = 2'h0;
    terminal_updown_pin = 2'h0;
    motor_set_terminal_pin = 1'b0;
    motor_terminal_assigned = 1'b0;
  end
  // level changes, each landing just after a rising edge
  task automatic set_run(input logic b);
    @(posedge core_clk) run_active <= b;
  endtask : set_run
  task automatic set_ch(input logic [1:0] c);
    @(posedge core_clk) cmd_channel <= c;
  endtask : set_ch
  task automatic set_op(input logic [15:0] f);
    @(posedge core_clk) operating_freq <= f;
  endtask : set_op
  task automatic set_src(input logic [15:0] f);
    @(posedge core_clk) source_freq <= f;
  endtask : set_src
  task automatic set_motor(input logic assigned, input logic pin);
    @(posedge core_clk) begin
      motor_terminal_assigned <= assigned;
      motor_set_terminal_pin <= pin;
    end
  endtask : set_motor
  // one key step: {up,down}
  task automatic key(input logic [1:0] k);
    @(posedge core_clk) keypad_updown <= k;
    @(posedge core_clk) keypad_updown <= 2'h0;
  endtask : key
  // slow terminal step, held long enough for the pin filter
  task automatic term(input logic [1:0] k);
    @(posedge core_clk) terminal_updown_pin <= k;
    repeat (6) @(posedge core_clk);
    terminal_updown_pin <= 2'h0;
    repeat (6) @(posedge core_clk);
  endtask : term
endmodule : drive_partner

//--- sim/setpoint_source_selector_tb.sv
/*
  setpoint_source_selector_tb: self-checking bench over the Avalon-MM port and drive pins.
  assumes the design package and drive_partner are compiled first.
*/
`timescale 1ns/1ns
module setpoint_source_selector_tb;
  import selector_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] avs_byteenable = 4'hF;
  logic run_active, serial_protocol;
  logic [1:0] cmd_channel, keypad_updown, terminal_updown_pin;
  logic [15:0] operating_freq, source_freq, target_freq, ramp_ref_freq;
  logic motor_set_terminal_pin, motor_terminal_assigned;
  drive_sel_t drive_sel;
  int mismatches = 0;
  int n_compared = 0;
  logic [31:0] rd;

  always #4 core_clk = ~core_clk;

  drive_partner far (.core_clk(core_clk), .run_active(run_active),
    .cmd_channel(cmd_channel), .operating_freq(operating_freq), .source_freq(source_freq),
    .keypad_updown(keypad_updown), .terminal_updown_pin(terminal_updown_pin),
    .motor_set_terminal_pin(motor_set_terminal_pin),
    .motor_terminal_assigned(motor_terminal_assigned));

  setpoint_source_selector dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .run_active(run_active), .cmd_channel(cmd_channel),
    .operating_freq(operating_freq), .source_freq(source_freq),
    .keypad_updown(keypad_updown), .terminal_updown_pin(terminal_updown_pin),
    .motor_set_terminal_pin(motor_set_terminal_pin),
    .motor_terminal_assigned(motor_terminal_assigned), .drive_sel(drive_sel),
    .target_freq(target_freq), .ramp_ref_freq(ramp_ref_freq),
    .serial_protocol(serial_protocol));

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one bus cycle; request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_read <= ~wr;
    avs_write <= wr;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) begin
        rd = avs_readdata;
        break;
      end
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20) begin
      mismatches++;
      $display("unexpected at %0t: wait %h expected %h", $time, avs_waitrequest, 1'b0);
      end_sim();
    end
  endtask : bus

  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 16'h0);
    chk(rd, exp);
  endtask : rchk

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic t_reset;
    logic [15:0] exp [9] = '{16'h1, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1388,
      16'h1388, 16'h1};
    for (int i = 0; i < 9; i++) rchk(4'(i), {16'h0, exp[i]});
    rchk(4'hC, 32'h0);
    bus(1'b1, IDX_TARGET, 16'h0055);
    rchk(IDX_TARGET, 32'h1388);
    avs_byteenable <= 4'h1;
    bus(1'b1, IDX_PRESET, 16'hAB11);
    avs_byteenable <= 4'hF;
    rchk(IDX_PRESET, 32'h1311);
    chk(32'(drive_sel), 32'h01);
    chk(ramp_ref_freq, 32'h1388);
    $display("test reset done");
  endtask : t_reset

  task automatic t_nomem;
    bus(1'b1, IDX_STOP_MEM, 16'h0);
    bus(1'b1, IDX_PRESET, 16'h1000);
    far.set_run(1'b1);
    far.set_op(16'h0F00);
    far.key(2'b10);
    settle(3);
    chk(target_freq, 32'h0F01);
    far.term(2'b01);
    settle(2);
    chk(target_freq, 32'h0EFF);
    far.set_run(1'b0);
    settle(3);
    chk(target_freq, 32'h1000);
    rchk(IDX_SETPOINT, 32'h1000);
    $display("test no memory done");
  endtask : t_nomem

  task automatic t_mem;
    bus(1'b1, IDX_STOP_MEM, 16'h1);
    bus(1'b1, IDX_CORR_BASE, 16'h1);
    far.set_run(1'b1);
    far.key(2'b10);
    far.term(2'b10);
    settle(2);
    chk(target_freq, 32'h1002);
    far.set_run(1'b0);
    settle(3);
    chk(target_freq, 32'h1002);
    bus(1'b1, IDX_RAMP_REF, 16'h1);
    settle(2);
    chk(ramp_ref_freq, 32'h1002);
    far.set_run(1'b1);
    far.key(2'b01);
    settle(3);
    chk(ramp_ref_freq, 32'h1001);
    bus(1'b1, IDX_RAMP_REF, 16'h2);
    settle(2);
    chk(ramp_ref_freq, 32'h2710);
    bus(1'b1, IDX_RAMP_REF, 16'h3);
    settle(2);
    chk(ramp_ref_freq, 32'h1388);
    far.set_op(16'h1388);
    bus(1'b1, IDX_CORR_BASE, 16'h0);
    far.key(2'b10);
    settle(3);
    chk(target_freq, 32'h1388);
    far.set_op(16'h0000);
    far.key(2'b01);
    settle(3);
    chk(target_freq, 32'h0);
    bus(1'b1, IDX_STOP_MEM, 16'h0);
    far.set_run(1'b0);
    settle(3);
    chk(target_freq, 32'h1000);
    $display("test memory done");
  endtask : t_mem

  task automatic t_source;
    logic [3:0] s;
    far.set_src(16'h0800);
    bus(1'b1, IDX_PRESET, 16'h0900);
    bus(1'b1, IDX_MAIN_SRC, 16'h2);
    far.set_run(1'b1);
    far.key(2'b10);
    far.set_run(1'b0);
    settle(3);
    chk(target_freq, 32'h0800);
    rchk(IDX_SETPOINT, 32'h1000);
    chk(32'(drive_sel), 32'h02);
    bus(1'b1, IDX_BINDING, 16'h0321);
    for (int c = 0; c < 3; c++) begin
      far.set_ch(2'(c));
      settle(3);
      chk(32'(drive_sel), 32'h10 | (c + 1));
    end
    bus(1'b1, IDX_BINDING, 16'h0111);
    for (int c = 0; c < 3; c++) begin
      far.set_ch(2'(c));
      settle(3);
      chk(32'(drive_sel), 32'h11);
      chk(target_freq, 32'h1000);
    end
    for (int d = 0; d < 10; d++) begin
      s = (d == 0) ? 4'h2 : 4'(d);
      bus(1'b1, IDX_BINDING, 16'(d) << 8);
      settle(2);
      chk(32'(drive_sel), {27'h0, d != 0, s});
    end
    far.set_ch(2'h3);
    settle(3);
    chk(32'(drive_sel), 32'h02);
    $display("test source done");
  endtask : t_source

  task automatic t_motor;
    bus(1'b1, IDX_MOTOR_SET, 16'h1);
    settle(2);
    chk(drive_sel.motor_set, 32'h1);
    far.set_motor(1'b1, 1'b0);
    settle(8);
    chk(drive_sel.motor_set, 32'h0);
    bus(1'b1, IDX_MOTOR_SET, 16'h0);
    far.set_motor(1'b1, 1'b1);
    settle(8);
    chk(drive_sel.motor_set, 32'h1);
    rchk(IDX_STATUS, {24'h0, 4'h2, 4'h1});
    far.set_motor(1'b0, 1'b1);
    settle(3);
    chk(drive_sel.motor_set, 32'h0);
    $display("test motor done");
  endtask : t_motor

  task automatic t_proto;
    bus(1'b1, IDX_PROTOCOL, 16'h1);
    settle(2);
    chk(serial_protocol, 32'h1);
    bus(1'b1, IDX_PROTOCOL, 16'h0);
    settle(2);
    chk(serial_protocol, 32'h0);
    $display("test protocol done");
  endtask : t_proto

  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    settle(2);
    t_reset();
    t_nomem();
    t_mem();
    t_source();
    t_motor();
    t_proto();
    end_sim();
  end
endmodule : setpoint_source_selector_tb
